// ### core/fla_arbiter.sv
// Contract
// - Priority pair 11 highest, 00 lowest.
// - Each source has high and low priority bit.
// - Lower level never preempts running routine.
// - Higher level wins among pending requests.
// - Fixed polling order breaks equal-level ties.
// - Vector is 0003H plus eight per source.
// - Per-source enables, global enable gates all.
// - External inputs level or edge per type.
// - Edge flags cleared on call; level follows pin.
// - Timer A and B flags cleared on call.
// - Other flags never cleared by vectoring.
// - Counter array request ORs seven flags.
// - Keypad and brownout flags raise requests.
// - Software flag writes act like hardware; level-type external flags here ignore them and follow the pin.
// - Flags sampled, polled one clock later.
// - Unblocked pending request issues long call.
// - Equal or higher level in progress blocks.
// - Only final instruction cycle may vector.
// - Return or control write blocks one instruction.
// - Blocked requests are not remembered.
// - Extended priority bits five down to zero.
// - Polarity bit selects high or rising.
module fla_arbiter
(
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Special function register port.
	input  wire logic [7:0]           sfr_addr_i,
	input  wire logic                 sfr_we_i,
	input  wire logic [7:0]           sfr_wdata_i,
	output logic      [7:0]           sfr_rdata_o,
	// Instruction sequencer status.
	input  wire fla_pkg::fla_instr_t  instr_i,
	// External interrupt pins, active low by default.
	input  wire logic [3:0]           ext_input_i,
	// Peripheral flags.
	input  wire logic                 timer_a_overflow_i,
	input  wire logic                 timer_b_overflow_i,
	input  wire logic                 timer_c_overflow_i,
	input  wire logic                 timer_c_external_flag_i,
	input  wire logic                 serial_a_rx_flag_i,
	input  wire logic                 serial_a_tx_flag_i,
	input  wire logic                 serial_b_rx_flag_i,
	input  wire logic                 serial_b_tx_flag_i,
	input  wire logic                 sync_serial_flag_i,
	input  wire logic                 converter_done_flag_i,
	input  wire logic                 array_counter_overflow_i,
	input  wire logic [5:0]           array_module_flag_i,
	input  wire logic                 brownout_flag_i,
	input  wire logic                 keypad_match_flag_i,
	// Call request, flag clears and levels in progress.
	output fla_pkg::fla_call_t        call_o,
	output logic                      timer_a_clear_o,
	output logic                      timer_b_clear_o,
	output logic      [3:0]           level_active_o
);

	// ****************************************************************
	// Registers.
	// ****************************************************************
	logic [7:0] irq_enable_reg_q;
	logic [7:0] ext_enable_reg_q;
	logic [7:0] ext_ctrl_q;
	logic [7:0] ext01_ctrl_q;
	logic [7:0] base_prio_high_q;
	logic [7:0] base_prio_low_q;
	logic [7:0] ext_prio_high_q;
	logic [7:0] ext_prio_low_q;
	logic [7:0] rdata_q;

	localparam int NUM_SRC_W = fla_pkg::NUM_SRC;

	logic [3:0] ext_flag_q;
	logic [3:0] ext_active_prev_q;
	logic [NUM_SRC_W-1:0] sample_q;
	logic [3:0] in_progress_q;
	logic       block_pending_q;

	fla_pkg::fla_call_t call_q;
	logic       timer_a_clear_q;
	logic       timer_b_clear_q;

	logic [NUM_SRC_W-1:0] raw_req;
	logic [NUM_SRC_W-1:0] enable_vec;
	logic [NUM_SRC_W-1:0] prio_high_vec;
	logic [NUM_SRC_W-1:0] prio_low_vec;
	logic [3:0] ext_type;
	logic [3:0] ext_pol;
	logic [3:0] ext_sw_we;
	logic [3:0] ext_sw_val;
	logic [3:0] ext_active;
	logic       ctrl_write;
	logic       fire;
	logic       sel_valid;
	logic [3:0] sel_src;
	logic [1:0] sel_level;
	logic       level_blocked;
	logic [3:0] release_mask;

	// ****************************************************************
	// Register writes.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_enable_reg_q <= fla_pkg::RST_REG;
			ext_enable_reg_q <= fla_pkg::RST_REG;
			base_prio_high_q <= fla_pkg::RST_REG;
			base_prio_low_q  <= fla_pkg::RST_REG;
			ext_prio_high_q  <= fla_pkg::RST_REG;
			ext_prio_low_q   <= fla_pkg::RST_REG;
		end
		else if (sfr_we_i)
		begin
			case (sfr_addr_i)
				fla_pkg::ADDR_IRQ_ENABLE:    irq_enable_reg_q <= sfr_wdata_i & fla_pkg::MASK_IRQ_EN;
				fla_pkg::ADDR_EXT_ENABLE:    ext_enable_reg_q <= sfr_wdata_i & fla_pkg::MASK_EXT_BANK;
				fla_pkg::ADDR_BASE_PRIO_HI:  base_prio_high_q <= sfr_wdata_i;
				fla_pkg::ADDR_BASE_PRIO_LO:  base_prio_low_q  <= sfr_wdata_i;
				// Reserved upper bits are dropped even if software sets them.
				fla_pkg::ADDR_EXT_PRIO_HIGH: ext_prio_high_q  <= sfr_wdata_i & fla_pkg::MASK_EXT_BANK;
				fla_pkg::ADDR_EXT_PRIO_LOW:  ext_prio_low_q   <= sfr_wdata_i & fla_pkg::MASK_EXT_BANK;
				default:
				begin
				end
			endcase
		end
	end

	// Control bits of the external inputs; their flags are held separately.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_ctrl_q   <= fla_pkg::RST_REG;
			ext01_ctrl_q <= fla_pkg::RST_REG;
		end
		else if (sfr_we_i && sfr_addr_i == fla_pkg::ADDR_EXT_CONTROL)
		begin
			ext_ctrl_q <= sfr_wdata_i;
		end
		else if (sfr_we_i && sfr_addr_i == fla_pkg::ADDR_EXT01_CONTROL)
		begin
			ext01_ctrl_q <= sfr_wdata_i & fla_pkg::MASK_EXT01;
		end
	end

	// ****************************************************************
	// Read data, registered one clock after the address.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdata_q <= fla_pkg::RST_REG;
		end
		else
		begin
			case (sfr_addr_i)
				fla_pkg::ADDR_IRQ_ENABLE:    rdata_q <= irq_enable_reg_q;
				fla_pkg::ADDR_EXT_ENABLE:    rdata_q <= ext_enable_reg_q;
				fla_pkg::ADDR_BASE_PRIO_HI:  rdata_q <= base_prio_high_q;
				fla_pkg::ADDR_BASE_PRIO_LO:  rdata_q <= base_prio_low_q;
				fla_pkg::ADDR_EXT_PRIO_HIGH: rdata_q <= ext_prio_high_q;
				fla_pkg::ADDR_EXT_PRIO_LOW:  rdata_q <= ext_prio_low_q;
				fla_pkg::ADDR_EXT_CONTROL:
					rdata_q <= {ext_ctrl_q[7:6], ext_flag_q[3], ext_ctrl_q[4:2], ext_flag_q[2], ext_ctrl_q[0]};
				fla_pkg::ADDR_EXT01_CONTROL:
					rdata_q <= {4'h0, ext_flag_q[1], ext01_ctrl_q[2], ext_flag_q[0], ext01_ctrl_q[0]};
				default:                     rdata_q <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// External input flags.
	// ****************************************************************
	always_comb
	begin
		ext_type = {ext_ctrl_q[fla_pkg::BIT_X_TYPE3], ext_ctrl_q[fla_pkg::BIT_X_TYPE2],
		            ext01_ctrl_q[fla_pkg::BIT_E01_TYPE1], ext01_ctrl_q[fla_pkg::BIT_E01_TYPE0]};
		ext_pol  = {ext_ctrl_q[fla_pkg::BIT_X_POL3], ext_ctrl_q[fla_pkg::BIT_X_POL2], 2'b00};
		ext_sw_val = {sfr_wdata_i[fla_pkg::BIT_X_FLAG3], sfr_wdata_i[fla_pkg::BIT_X_FLAG2],
		              sfr_wdata_i[fla_pkg::BIT_E01_FLAG1], sfr_wdata_i[fla_pkg::BIT_E01_FLAG0]};
		ext_sw_we[3:2] = {2{sfr_we_i && sfr_addr_i == fla_pkg::ADDR_EXT_CONTROL}};
		ext_sw_we[1:0] = {2{sfr_we_i && sfr_addr_i == fla_pkg::ADDR_EXT01_CONTROL}};
	end

	genvar ch;
	generate
		for (ch = 0; ch < fla_pkg::NUM_EXT; ch++)
		begin : g_ext
			logic hw_clear;
			logic edge_seen;

			// Pins are low-active unless the polarity bit turns them round.
			assign ext_active[ch] = ext_pol[ch] ? ext_input_i[ch] : ~ext_input_i[ch];
			assign edge_seen      = ext_active[ch] & ~ext_active_prev_q[ch];
			assign hw_clear       = fire && sel_src == 4'((ch < 2) ? ch * 2 : ch + 4);

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					ext_active_prev_q[ch] <= 1'b0;
					ext_flag_q[ch]        <= 1'b0;
				end
				else
				begin
					ext_active_prev_q[ch] <= ext_active[ch];
					if (!ext_type[ch])
						ext_flag_q[ch] <= ext_active[ch];
					else if (edge_seen)
						ext_flag_q[ch] <= 1'b1;
					else if (ext_sw_we[ch])
						ext_flag_q[ch] <= ext_sw_val[ch];
					else if (hw_clear)
						ext_flag_q[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Request, enable and priority vectors in polling order.
	// ****************************************************************
	always_comb
	begin
		raw_req = {keypad_match_flag_i,
		           serial_b_rx_flag_i | serial_b_tx_flag_i,
		           brownout_flag_i,
		           array_counter_overflow_i | (|array_module_flag_i),
		           converter_done_flag_i,
		           sync_serial_flag_i,
		           ext_flag_q[3],
		           ext_flag_q[2],
		           timer_c_overflow_i | timer_c_external_flag_i,
		           serial_a_rx_flag_i | serial_a_tx_flag_i,
		           timer_b_overflow_i,
		           ext_flag_q[1],
		           timer_a_overflow_i,
		           ext_flag_q[0]};
		enable_vec = {ext_enable_reg_q[5:0], ext_ctrl_q[fla_pkg::BIT_X_EN3], ext_ctrl_q[fla_pkg::BIT_X_EN2],
		              irq_enable_reg_q[5:0]};
		prio_high_vec = {ext_prio_high_q[5:0], base_prio_high_q};
		prio_low_vec  = {ext_prio_low_q[5:0], base_prio_low_q};
	end

	// Flags are sampled here and polled from the sample a clock later.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sample_q <= '0;
		else
			sample_q <= raw_req;
	end

	// ****************************************************************
	// Selection.
	// ****************************************************************
	always_comb
	begin
		logic [NUM_SRC_W-1:0] pend;
		logic [1:0]           lvl;
		lvl       = 2'b00;
		pend      = sample_q & enable_vec & {NUM_SRC_W{irq_enable_reg_q[fla_pkg::BIT_GLOBAL_EN]}};
		sel_valid = 1'b0;
		sel_src   = 4'h0;
		sel_level = 2'b00;
		// Ascending scan with strict compare keeps the first source of the best level.
		for (int i = 0; i < NUM_SRC_W; i++)
		begin
			lvl = {prio_high_vec[i], prio_low_vec[i]};
			if (pend[i] && (!sel_valid || lvl > sel_level))
			begin
				sel_valid = 1'b1;
				sel_src   = 4'(i);
				sel_level = lvl;
			end
		end
	end

	always_comb
	begin
		level_blocked = 1'b0;
		for (int j = 0; j < 4; j++)
			if (in_progress_q[j] && 2'(j) >= sel_level)
				level_blocked = 1'b1;
	end

	// A register of the block, or a return, blocks the rest of the instruction.
	assign ctrl_write = sfr_we_i && (sfr_addr_i == fla_pkg::ADDR_IRQ_ENABLE
	                    || sfr_addr_i == fla_pkg::ADDR_EXT_CONTROL || sfr_addr_i == fla_pkg::ADDR_EXT_ENABLE
	                    || sfr_addr_i == fla_pkg::ADDR_EXT_PRIO_LOW || sfr_addr_i == fla_pkg::ADDR_EXT_PRIO_HIGH
	                    || sfr_addr_i == fla_pkg::ADDR_BASE_PRIO_HI || sfr_addr_i == fla_pkg::ADDR_BASE_PRIO_LO
	                    || sfr_addr_i == fla_pkg::ADDR_EXT01_CONTROL);

	// Nothing is latched per request: each cycle decides from the current sample.
	assign fire = sel_valid && !level_blocked && instr_i.last_cycle
	              && !instr_i.return_from_irq && !ctrl_write && !block_pending_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			block_pending_q <= 1'b0;
		else if (instr_i.last_cycle)
			block_pending_q <= 1'b0;
		else if (ctrl_write || instr_i.return_from_irq)
			block_pending_q <= 1'b1;
	end

	// ****************************************************************
	// Levels in progress.
	// ****************************************************************
	always_comb
	begin
		release_mask = 4'h0;
		for (int k = 0; k < 4; k++)
			if (in_progress_q[k])
				release_mask = 4'h1 << k;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			in_progress_q <= 4'h0;
		else if (fire)
			in_progress_q <= in_progress_q | (4'h1 << sel_level);
		else if (instr_i.return_from_irq && instr_i.last_cycle)
			in_progress_q <= in_progress_q & ~release_mask;
	end

	// ****************************************************************
	// Call outputs.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			call_q          <= '0;
			timer_a_clear_q <= 1'b0;
			timer_b_clear_q <= 1'b0;
		end
		else
		begin
			call_q.valid    <= fire;
			call_q.source   <= sel_src;
			call_q.level    <= sel_level;
			call_q.vector   <= fla_pkg::VEC_BASE + 16'(sel_src) * fla_pkg::VEC_STEP;
			timer_a_clear_q <= fire && sel_src == 4'(fla_pkg::SRC_TIMER_A);
			timer_b_clear_q <= fire && sel_src == 4'(fla_pkg::SRC_TIMER_B);
		end
	end

	// Remaining peripheral flags get no clear here; they stay with software.
	assign sfr_rdata_o     = rdata_q;
	assign call_o          = call_q;
	assign timer_a_clear_o = timer_a_clear_q;
	assign timer_b_clear_o = timer_b_clear_q;
	assign level_active_o  = in_progress_q;

endmodule

// ### pkg/fla_pkg.sv
package fla_pkg;

	// ****************************************************************
	// Register addresses on the special function register port.
	// ****************************************************************
	localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'hE8;
	localparam logic [7:0] ADDR_EXT_CONTROL   = 8'hC0;
	localparam logic [7:0] ADDR_EXT_ENABLE    = 8'hAD;
	localparam logic [7:0] ADDR_EXT_PRIO_LOW  = 8'hAE;
	localparam logic [7:0] ADDR_EXT_PRIO_HIGH = 8'hAF;
	localparam logic [7:0] ADDR_BASE_PRIO_HI  = 8'hB7;
	localparam logic [7:0] ADDR_BASE_PRIO_LO  = 8'hB8;
	localparam logic [7:0] ADDR_EXT01_CONTROL = 8'hC1;

	// ****************************************************************
	// Reset values and writable masks.
	// ****************************************************************
	localparam logic [7:0] RST_REG        = 8'h00;
	localparam logic [7:0] MASK_IRQ_EN    = 8'hBF;
	localparam logic [7:0] MASK_EXT_BANK  = 8'h3F;
	localparam logic [7:0] MASK_EXT01     = 8'h0F;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int BIT_GLOBAL_EN   = 7;
	localparam int BIT_X_EN2       = 2;
	localparam int BIT_X_EN3       = 6;
	localparam int BIT_X_TYPE2     = 0;
	localparam int BIT_X_FLAG2     = 1;
	localparam int BIT_X_POL2      = 3;
	localparam int BIT_X_TYPE3     = 4;
	localparam int BIT_X_FLAG3     = 5;
	localparam int BIT_X_POL3      = 7;
	localparam int BIT_E01_TYPE0   = 0;
	localparam int BIT_E01_FLAG0   = 1;
	localparam int BIT_E01_TYPE1   = 2;
	localparam int BIT_E01_FLAG1   = 3;

	// ****************************************************************
	// Sources in polling order and vector layout.
	// ****************************************************************
	localparam int NUM_SRC = 14;
	localparam int NUM_EXT = 4;
	localparam int SRC_TIMER_A = 1;
	localparam int SRC_TIMER_B = 3;
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam logic [15:0] VEC_STEP  = 16'h0008;
	localparam logic [1:0]  LEVEL_TOP = 2'h3;

	typedef struct packed {
		logic last_cycle;
		logic return_from_irq;
	} fla_instr_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] vector;
		logic [3:0]  source;
		logic [1:0]  level;
	} fla_call_t;

endpackage

// ### sim/fla_arbiter_sva.sv
module fla_arbiter_sva
(
	// Clock and reset.
	input wire logic                clk_i,
	input wire logic                rst_i,
	// Inputs watched.
	input wire logic [7:0]          sfr_addr_i,
	input wire logic                sfr_we_i,
	input wire logic [7:0]          sfr_wdata_i,
	input wire fla_pkg::fla_instr_t instr_i,
	// Outputs watched.
	input wire fla_pkg::fla_call_t  call_o,
	input wire logic                timer_a_clear_o,
	input wire logic                timer_b_clear_o,
	input wire logic [3:0]          level_active_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic global_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************************************
	// Mirror of the global enable bit, kept from register writes.
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			global_q <= 1'b0;
		else if (sfr_we_i && sfr_addr_i == fla_pkg::ADDR_IRQ_ENABLE)
			global_q <= sfr_wdata_i[fla_pkg::BIT_GLOBAL_EN];
	end

	property p_vec; call_o.valid |-> call_o.vector == fla_pkg::VEC_BASE + fla_pkg::VEC_STEP * call_o.source; endproperty
	a_vec: assert property (p_vec) else $error("call vector does not match source");
	property p_clr; timer_a_clear_o == (call_o.valid && call_o.source == 4'h1); endproperty
	a_clr: assert property (p_clr) else $error("timer clear pulse wrong");
	property p_clrb; timer_b_clear_o == (call_o.valid && call_o.source == 4'h3); endproperty
	a_clrb: assert property (p_clrb) else $error("second timer clear pulse wrong");
	property p_glob; call_o.valid |-> global_q; endproperty
	a_glob: assert property (p_glob) else $error("call while globally disabled");
	property p_last; call_o.valid |-> $past(instr_i.last_cycle); endproperty
	a_last: assert property (p_last) else $error("call outside final instruction cycle");
	property p_ret; call_o.valid |-> !$past(instr_i.return_from_irq); endproperty
	a_ret: assert property (p_ret) else $error("call during a return");
	property p_lvl; call_o.valid |-> level_active_o[call_o.level]; endproperty
	a_lvl: assert property (p_lvl) else $error("called level not marked active");
	property p_pre; call_o.valid |-> ($past(level_active_o) >> call_o.level) == 4'h0; endproperty
	a_pre: assert property (p_pre) else $error("call preempts equal or higher level");
	property p_rel;
		instr_i.return_from_irq && instr_i.last_cycle && level_active_o != 4'h0 |=>
			$onehot($past(level_active_o) ^ level_active_o) && ($past(level_active_o) ^ level_active_o) > level_active_o;
	endproperty
	a_rel: assert property (p_rel) else $error("return did not release top level");

	c_top: cover property (call_o.valid && call_o.level == 2'h3);
	c_clr: cover property (timer_a_clear_o);
	c_rel: cover property (instr_i.return_from_irq && level_active_o != 4'h0);
endmodule

bind fla_arbiter fla_arbiter_sva i_fla_arbiter_sva
(
	.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_we_i(sfr_we_i), .sfr_wdata_i(sfr_wdata_i),
	.instr_i(instr_i), .call_o(call_o), .timer_a_clear_o(timer_a_clear_o), .timer_b_clear_o(timer_b_clear_o),
	.level_active_o(level_active_o)
);

// ### sim/fla_core_model.sv
module fla_core_model
(
	// Clock and reset.
	input wire logic            clk_i,
	input wire logic            rst_i,
	// Commands from the bench.
	input wire logic            slow_i,
	input wire logic            ret_req_i,
	input wire logic [1:0]      tset_i,
	input wire logic            tclr_i,
	// Hardware clear pulses from the arbiter.
	input wire logic [1:0]      hclr_i,
	// Sequencer status and timer flags.
	output fla_pkg::fla_instr_t instr_o,
	output logic [1:0]          tflag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;
	logic       pend_q;
	logic       ret_q;

	assign instr_o = {!slow_i || cnt_q == 2'h2, ret_q};

	// Instructions last one or three cycles; a requested return starts at the next boundary.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 2'h0;
			pend_q <= 1'b0;
			ret_q  <= 1'b0;
		end
		else if (instr_o.last_cycle)
		begin
			cnt_q  <= 2'h0;
			ret_q  <= pend_q || ret_req_i;
			pend_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_q + 2'h1;
			pend_q <= pend_q || ret_req_i;
		end
	end

	// Rollover sets a timer flag; the arbiter's call or software clears it.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tflag_o <= 2'h0;
		else
			tflag_o <= tset_i | (tflag_o & ~hclr_i & {2{!tclr_i}});
	end
endmodule

// ### sim/tb_fla_arbiter.sv
module tb_fla_arbiter;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i;
	logic rst_i;
	logic [7:0] sfr_addr;
	logic sfr_we;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic [13:0] req_q;
	logic on_q;
	logic [7:0] rnd_q;
	logic [3:0] pin_x;
	logic slow_q;
	logic ret_req;
	logic [1:0] tset;
	logic tclr;
	logic [1:0] tflag;
	logic [3:0] level_active;
	logic tca;
	logic tcb;
	fla_pkg::fla_instr_t instr;
	fla_pkg::fla_call_t call;
	fla_pkg::fla_call_t cq;
	int err_total = 0;
	int comparisons = 0;
	int ncall = 0;
	logic [7:0] ad [9] = '{8'hE8, 8'hC0, 8'hAD, 8'hAE, 8'hAF, 8'hB7, 8'hB8, 8'hC1, 8'hFF};
	logic [7:0] msk [9] = '{8'hBF, 8'h00, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00};
	wire logic [13:0] r = req_q & {14{on_q}};

	fla_arbiter i_fla_arbiter
	(
		.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr), .sfr_we_i(sfr_we), .sfr_wdata_i(sfr_wdata),
		.sfr_rdata_o(sfr_rdata), .instr_i(instr), .ext_input_i(~{r[7], r[6], r[2], r[0]} ^ pin_x),
		.timer_a_overflow_i(tflag[0]), .timer_b_overflow_i(tflag[1]),
		.timer_c_overflow_i(r[5] & rnd_q[1]), .timer_c_external_flag_i(r[5] & !rnd_q[1]),
		.serial_a_rx_flag_i(r[4] & rnd_q[0]), .serial_a_tx_flag_i(r[4] & !rnd_q[0]),
		.serial_b_rx_flag_i(r[12] & rnd_q[2]), .serial_b_tx_flag_i(r[12] & !rnd_q[2]),
		.sync_serial_flag_i(r[8]), .converter_done_flag_i(r[9]), .array_counter_overflow_i(r[10] & rnd_q[3]),
		.array_module_flag_i({6{r[10] & !rnd_q[3]}} & {rnd_q[7:4], 2'h1}), .brownout_flag_i(r[11]),
		.keypad_match_flag_i(r[13]), .call_o(call), .timer_a_clear_o(tca), .timer_b_clear_o(tcb),
		.level_active_o(level_active)
	);

	fla_core_model i_fla_core_model
	(
		.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow_q), .ret_req_i(ret_req), .tset_i(tset), .tclr_i(tclr),
		.hclr_i({tcb, tca}), .instr_o(instr), .tflag_o(tflag)
	);

	initial clk_i = 1'b0;
	always #20 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		if (call.valid === 1'b1)
		begin
			ncall <= ncall + 1;
			cq <= call;
		end
	end

	// ****************************************************************
	// Checks, bus cycles and scenarios.
	// ****************************************************************
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		sfr_addr = a;
		sfr_we = 1'b1;
		sfr_wdata = d;
		@(negedge clk_i);
		sfr_we = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_i);
		sfr_addr = a;
		@(negedge clk_i);
		chk_reg(sfr_rdata, e);
	endtask

	task automatic expect_call(input logic [3:0] s, input logic [1:0] lv);
		int n0;
		n0 = ncall;
		for (int i = 0; i < 40 && ncall == n0; i++)
			@(negedge clk_i);
		chk_val(16'(ncall - n0), 16'h1);
		chk_val(cq.vector, 16'h0003 + 16'h0008 * s);
		chk_val({12'h0, cq.source}, {12'h0, s});
		chk_val({12'h0, level_active}, 16'h1 << lv);
	endtask

	task automatic no_call(input int n);
		int n0;
		n0 = ncall;
		repeat (n) @(negedge clk_i);
		chk_val(16'(ncall - n0), 16'h0);
	endtask

	task automatic ret();
		@(negedge clk_i);
		ret_req = 1'b1;
		@(negedge clk_i);
		ret_req = 1'b0;
		repeat (8) @(negedge clk_i);
		chk_reg({4'h0, level_active}, 8'h00);
	endtask

	// Highest level wins; among equals the lowest polling index.
	function automatic logic [5:0] pick(input logic [13:0] q, input logic [13:0] ph, input logic [13:0] pl);
		logic [3:0] w;
		logic [1:0] b;
		w = 4'hF;
		b = 2'h0;
		for (int i = 0; i < 14; i++)
			if (q[i] && (w == 4'hF || {ph[i], pl[i]} > b))
			begin
				w = 4'(i);
				b = {ph[i], pl[i]};
			end
		return {b, w};
	endfunction

	task automatic run_prio(input logic [13:0] q, input logic [13:0] ph, input logic [13:0] pl);
		logic [5:0] e;
		if (q == 14'h0)
			q = 14'h2000;
		e = pick(q, ph, pl);
		wr(8'hB7, ph[7:0]);
		wr(8'hB8, pl[7:0]);
		wr(8'hAF, {2'h0, ph[13:8]});
		wr(8'hAE, {2'h0, pl[13:8]});
		wr(8'hE8, 8'h3F);
		wr(8'hAD, 8'h3F);
		wr(8'hC0, 8'h44);
		wr(8'hC1, 8'h00);
		@(negedge clk_i);
		req_q = q;
		on_q = 1'b1;
		rnd_q = 8'($urandom);
		slow_q = rnd_q[5];
		tset = {q[3], q[1]};
		@(negedge clk_i);
		tset = 2'h0;
		no_call(6);
		wr(8'hE8, 8'hBF);
		expect_call(e[3:0], e[5:4]);
		no_call(12);
		on_q = 1'b0;
		tclr = 1'b1;
		wr(8'hE8, 8'h00);
		tclr = 1'b0;
		ret();
	endtask

	initial
	begin
		logic [7:0] d;
		{sfr_addr, sfr_we, sfr_wdata, req_q, on_q, rnd_q, pin_x, slow_q, ret_req, tset, tclr} = '0;
		rst_i = 1'b1;
		void'($urandom(32'h92C41058));
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		foreach (ad[i])
			rd(ad[i], 8'h00);
		foreach (ad[i])
		begin
			d = 8'($urandom) & (ad[i] == 8'hFF ? 8'hFF : msk[i]);
			wr(ad[i], d);
			rd(ad[i], d & msk[i]);
		end
		wr(8'hE8, 8'h00);
		repeat (12) run_prio(14'($urandom), 14'($urandom), 14'($urandom));
		run_prio(14'h3FFF, 14'h2000, 14'h2000);
		req_q = 14'h0200;
		on_q = 1'b1;
		repeat (3) @(negedge clk_i);
		on_q = 1'b0;
		wr(8'hE8, 8'h80);
		no_call(10);
		wr(8'hE8, 8'h00);
		run_prio(14'h3FFF, 14'h0000, 14'h0000);
		wr(8'hC1, 8'h01);
		wr(8'hE8, 8'h81);
		pin_x = 4'h1;
		expect_call(4'h0, 2'h0);
		rd(8'hC1, 8'h01);
		ret();
		no_call(10);
		wr(8'hC1, 8'h03);
		expect_call(4'h0, 2'h0);
		ret();
		wr(8'hC0, 8'h0D);
		pin_x = 4'h4;
		wr(8'hE8, 8'h80);
		no_call(8);
		pin_x = 4'h0;
		expect_call(4'h6, 2'h0);
		ret();
		give_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		give_verdict();
	end
endmodule
